//--- bench/cwbsc_host.sv
// host model that programs the serial chain and runs the mixer reference
`timescale 1ns/1ps
`default_nettype none
module cwbsc_host (
    input wire logic clk_i,
    input wire logic so_i,
    output logic sclk_o,
    output logic sd_o,
    output logic ld_n_o,
    output logic ref_o
);
    initial
    begin
        sclk_o = 1'b0;
        sd_o = 1'b0;
        ld_n_o = 1'b1;
        ref_o = 1'b0;
    end
    // ----
    // shift lsb first, collect what leaves the far end
    // ----
    task automatic send(input logic [46:0] w, input logic up, output logic [46:0] old);
        @(posedge clk_i) #1 ld_n_o = 1'b0;
        for (int i = 0; i < 47; i++)
        begin
            repeat (4) @(posedge clk_i);
            #1 sd_o = w[i];
            old[i] = so_i;
            repeat (4) @(posedge clk_i);
            #1 sclk_o = 1'b1;
            repeat (5) @(posedge clk_i);
            #1 sclk_o = 1'b0;
        end
        repeat (4) @(posedge clk_i);
        #1 ld_n_o = up;
        repeat (8) @(posedge clk_i);
        #1;
    endtask : send
    task automatic tick();
        @(posedge clk_i) #1 ref_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 ref_o = 1'b0;
        repeat (7) @(posedge clk_i);
        #1;
    endtask : tick
endmodule : cwbsc_host
`default_nettype wire

//--- bench/cwbsc_top_props.sv
// port checks for the serial configuration loader
`timescale 1ns/1ps
`default_nettype none
module cwbsc_top_props #(
    parameter int NUM_CH = 8,
    parameter int CFG_W = 47
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic SER_CLK_I,
    input wire logic LOAD_N_I,
    input wire logic POWER_DOWN_PIN_I,
    input wire logic SER_DATA_O,
    input wire cwbsc_pkg::cwbsc_front_end_t FRONT_END_O,
    input wire logic [NUM_CH-1:0] CH_ENABLE_O,
    input wire logic [4*NUM_CH-1:0] CH_PHASE_O,
    input wire logic [NUM_CH-1:0] LO_I_O,
    input wire logic [NUM_CH-1:0] LO_Q_O,
    input wire logic CONFIG_LOADED_O
);
    // ----
    // assertions
    // ----
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);
    property p_stk; CONFIG_LOADED_O |=> CONFIG_LOADED_O; endproperty
    a_stk: assert property (p_stk) else $error("loaded fell");
    property p_noen; !CONFIG_LOADED_O |-> CH_ENABLE_O == '0; endproperty
    a_noen: assert property (p_noen) else $error("on unloaded");
    property p_pd; POWER_DOWN_PIN_I [*6] |-> (CH_ENABLE_O | LO_I_O | LO_Q_O) == '0; endproperty
    a_pd: assert property (p_pd) else $error("pd ignored");
    property p_gate; ((LO_I_O | LO_Q_O) & ~CH_ENABLE_O) == '0; endproperty
    a_gate: assert property (p_gate) else $error("lo on off ch");
    property p_ofb;
        FRONT_END_O.open_feedback == (FRONT_END_O.amp_gain_select && FRONT_END_O.impedance_select[2]);
    endproperty
    a_ofb: assert property (p_ofb) else $error("open fb");
    property p_feh; $changed(FRONT_END_O) |-> LOAD_N_I && $past(LOAD_N_I, 3); endproperty
    a_feh: assert property (p_feh) else $error("fe moved");
    property p_phh; $changed(CH_PHASE_O) |-> LOAD_N_I && $past(LOAD_N_I, 3); endproperty
    a_phh: assert property (p_phh) else $error("phase moved");
    property p_shf; $changed(SER_DATA_O) |-> $past(SER_CLK_I, 3) && !$past(LOAD_N_I, 3); endproperty
    a_shf: assert property (p_shf) else $error("bad shift");
endmodule : cwbsc_top_props
bind cwbsc_top cwbsc_top_props #(.NUM_CH(NUM_CH), .CFG_W(CFG_W)) u_props (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .SER_CLK_I(SER_CLK_I), .LOAD_N_I(LOAD_N_I),
    .POWER_DOWN_PIN_I(POWER_DOWN_PIN_I), .SER_DATA_O(SER_DATA_O), .FRONT_END_O(FRONT_END_O),
    .CH_ENABLE_O(CH_ENABLE_O), .CH_PHASE_O(CH_PHASE_O), .LO_I_O(LO_I_O), .LO_Q_O(LO_Q_O),
    .CONFIG_LOADED_O(CONFIG_LOADED_O));
`default_nettype wire

//--- bench/tb.sv
// bench for the serial configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, ce, pd, sclk, sdat, ld_n, refo, sout, loaded;
    cwbsc_pkg::cwbsc_front_end_t fe;
    logic [7:0] en, lo_i, lo_q;
    logic [31:0] ph;
    logic [6:0] xfe = 7'h00;
    logic [31:0] xph = 32'h0000_0000;
    int num_errors = 0;
    int checked = 0;
    cwbsc_top DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SER_CLK_I(sclk),
        .SER_DATA_I(sdat), .LOAD_N_I(ld_n), .MIXER_REF_OSC_I(refo),
        .POWER_DOWN_PIN_I(pd), .SER_DATA_O(sout), .FRONT_END_O(fe),
        .CH_ENABLE_O(en), .CH_PHASE_O(ph), .LO_I_O(lo_i), .LO_Q_O(lo_q),
        .CONFIG_LOADED_O(loaded));
    cwbsc_host host (.clk_i(clk), .so_i(sout), .sclk_o(sclk), .sd_o(sdat),
        .ld_n_o(ld_n), .ref_o(refo));
    // ----
    // scenarios
    // ----
    task automatic chk(input string nm, input logic [46:0] e, input logic [46:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic int ix(input int s, input int k);
        return (k * 5 + s) % 16;
    endfunction : ix
    function automatic logic [7:0] xen(input int s);
        logic [7:0] e;
        for (int k = 0; k < 8; k++)
            e[k] = (k + s) % 3 != 0;
        return e;
    endfunction : xen
    task automatic t_cfg(input int s);
        logic [46:0] w, old;
        logic [31:0] xp;
        logic [3:0] p;
        w = {s[0], s[1:0], s[3:0], 40'h0};
        for (int k = 0; k < 8; k++)
        begin
            p = 4'(ix(s, k));
            xp[4*k +: 4] = p;
            w[5*k +: 5] = {p[0], p[1], p[2], p[3], (k + s) % 3 == 0};
        end
        host.send(w, 1'b0, old);
        chk("held front end", 47'(xfe), 47'(fe));
        chk("held phase", 47'(xph), 47'(ph));
        host.send(w, 1'b1, old);
        chk("chain out", w, old);
        xfe = {s[3] & s[2], s[3], s[2:0], s[1:0]};
        xph = xp;
        chk("front end", 47'(xfe), 47'(fe));
        chk("phase", 47'(xp), 47'(ph));
        chk("enable", {38'h0, 1'b1, xen(s)}, {38'h0, loaded, en});
    endtask : t_cfg
    task automatic t_lo(input int s);
        logic [7:0] e, xi, xq;
        e = xen(s);
        for (int n = 0; n < 17; n++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                xi[k] = e[k] && (ix(s, k) + n) % 16 >= 8;
                xq[k] = e[k] && (ix(s, k) + n + 4) % 16 >= 8;
            end
            chk("lo", 47'({xi, xq}), 47'({lo_i, lo_q}));
            host.tick();
        end
    endtask : t_lo
    task automatic t_ce();
        logic [15:0] lo;
        lo = {lo_i, lo_q};
        @(posedge clk) #1 ce = 1'b0;
        repeat (3) host.tick();
        chk("frozen lo", 47'(lo), 47'({lo_i, lo_q}));
        @(posedge clk) #1 ce = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("resumed lo", 47'(lo), 47'({lo_i, lo_q}));
    endtask : t_ce
    task automatic t_pd();
        @(posedge clk) #1 pd = 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("power down", 47'h0, 47'({en, lo_i, lo_q}));
    endtask : t_pd
    task automatic close_out();
        $display("mismatches %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #2000000;
        num_errors++;
        close_out();
    end
    initial
    begin
        rst_n = 1'b0;
        pd = 1'b0;
        ce = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("unloaded", 47'h0, 47'({loaded, en, lo_i, lo_q}));
        for (int s = 0; s < 16; s++)
            t_cfg(s);
        t_lo(15);
        t_ce();
        t_pd();
        close_out();
    end
endmodule : tb
`default_nettype wire

//--- rtl/cwbsc_defines.svh
// constants for the cw beamformer serial configuration block
`ifndef CWBSC_DEFINES_SVH
`define CWBSC_DEFINES_SVH

`define CWBSC_CFG_W 47
`define CWBSC_NUM_CH 8
`define CWBSC_CH_W 5
`define CWBSC_PH_W 4
`define CWBSC_BEAM_LSB 0
`define CWBSC_BEAM_MSB 39
`define CWBSC_IMP_LSB 40
`define CWBSC_IMP_MSB 42
`define CWBSC_GAIN_POS 43
`define CWBSC_AAF_LSB 44
`define CWBSC_AAF_MSB 45
`define CWBSC_SPARE_POS 46
`define CWBSC_OPEN_FB_POS 42
`define CWBSC_CFG_RESET 47'h0000_0000_0000
`define CWBSC_PH_RESET 4'h0
`define CWBSC_QUARTER 4'h4
`define CWBSC_SYNC_DEPTH 3

`endif

//--- rtl/cwbsc_pkg.sv
// types for the cw beamformer serial configuration block
`default_nettype none
package cwbsc_pkg;

    // front end settings taken at the strobe rising edge
    typedef struct packed {
        logic open_feedback;
        logic amp_gain_select;
        logic [2:0] impedance_select;
        logic [1:0] aaf_cutoff_select;
    } cwbsc_front_end_t;

    // programming state, one-hot
    typedef enum logic [2:0] {
        ST_UNPROG = 3'h1,
        ST_SHIFT = 3'h2,
        ST_RUN = 3'h4
    } cwbsc_state_t;

endpackage : cwbsc_pkg

`default_nettype wire

//--- rtl/cwbsc_top.sv
// serial configuration loader and lo phase dividers of the cw beamformer
`timescale 1ns/1ps
`default_nettype none
`include "cwbsc_defines.svh"

module cwbsc_top #(
    parameter int NUM_CH = `CWBSC_NUM_CH,
    parameter int CFG_W = `CWBSC_CFG_W
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic SER_CLK_I,
    input wire logic SER_DATA_I,
    input wire logic LOAD_N_I,
    input wire logic MIXER_REF_OSC_I,
    input wire logic POWER_DOWN_PIN_I,
    output logic SER_DATA_O,
    output cwbsc_pkg::cwbsc_front_end_t FRONT_END_O,
    output logic [NUM_CH-1:0] CH_ENABLE_O,
    output logic [4*NUM_CH-1:0] CH_PHASE_O,
    output logic [NUM_CH-1:0] LO_I_O,
    output logic [NUM_CH-1:0] LO_Q_O,
    output logic CONFIG_LOADED_O
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // bit at offset 1 weighs eight, offset 4 weighs one
    function automatic logic [3:0] phase_index(input logic [4:0] grp);
        phase_index = {grp[1], grp[2], grp[3], grp[4]};
    endfunction : phase_index

    // filtered level moves only when the last two stages agree
    function automatic logic filt_next(input logic [2:0] s, input logic cur);
        filt_next = (s[1] == s[2]) ? s[2] : cur;
    endfunction : filt_next

    // msb of the divider a quarter period ahead, index plus four
    function automatic logic quad_msb(input logic [3:0] d);
        quad_msb = d[3] ^ d[2];
    endfunction : quad_msb

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------

    logic [2:0] sclk_sync_reg;
    logic [2:0] sdat_sync_reg;
    logic [2:0] load_sync_reg;
    logic [2:0] ref_sync_reg;
    logic [2:0] pd_sync_reg;
    logic sclk_lvl_reg;
    logic load_lvl_reg;
    logic ref_lvl_reg;
    logic pd_lvl_reg;
    logic sclk_lvl_next;
    logic load_lvl_next;
    logic ref_lvl_next;
    logic pd_lvl_next;
    logic sclk_rise;
    logic load_rise;
    logic ref_rise;

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            sclk_sync_reg <= 3'h0;
            sdat_sync_reg <= 3'h0;
            load_sync_reg <= 3'h7;
            ref_sync_reg <= 3'h0;
            pd_sync_reg <= 3'h0;
        end
        else if (CE_I)
        begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], SER_CLK_I};
            sdat_sync_reg <= {sdat_sync_reg[1:0], SER_DATA_I};
            load_sync_reg <= {load_sync_reg[1:0], LOAD_N_I};
            ref_sync_reg <= {ref_sync_reg[1:0], MIXER_REF_OSC_I};
            pd_sync_reg <= {pd_sync_reg[1:0], POWER_DOWN_PIN_I};
        end
    end

    always_comb
    begin
        sclk_lvl_next = filt_next(sclk_sync_reg, sclk_lvl_reg);
        load_lvl_next = filt_next(load_sync_reg, load_lvl_reg);
        ref_lvl_next = filt_next(ref_sync_reg, ref_lvl_reg);
        pd_lvl_next = filt_next(pd_sync_reg, pd_lvl_reg);
        sclk_rise = CE_I && sclk_lvl_next && !sclk_lvl_reg;
        load_rise = CE_I && load_lvl_next && !load_lvl_reg;
        ref_rise = CE_I && ref_lvl_next && !ref_lvl_reg;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            sclk_lvl_reg <= 1'h0;
            load_lvl_reg <= 1'h1;
            ref_lvl_reg <= 1'h0;
            pd_lvl_reg <= 1'h0;
        end
        else if (CE_I)
        begin
            sclk_lvl_reg <= sclk_lvl_next;
            load_lvl_reg <= load_lvl_next;
            ref_lvl_reg <= ref_lvl_next;
            pd_lvl_reg <= pd_lvl_next;
        end
    end

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------

    logic [CFG_W-1:0] shift_reg;

    // lsb enters first and ends at bit 0 after a full word
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            shift_reg <= `CWBSC_CFG_RESET;
        end
        else if (sclk_rise && !load_lvl_reg)
        begin
            shift_reg <= {sdat_sync_reg[2], shift_reg[CFG_W-1:1]};
        end
    end

    // bit leaving the low end feeds the next device in the chain
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            SER_DATA_O <= 1'h0;
        end
        else if (CE_I)
        begin
            SER_DATA_O <= shift_reg[0];
        end
    end

    // ------------------------------------------------------------
    // programming state
    // ------------------------------------------------------------

    cwbsc_pkg::cwbsc_state_t state_reg;
    cwbsc_pkg::cwbsc_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            cwbsc_pkg::ST_UNPROG:
            begin
                if (!load_lvl_reg)
                begin
                    state_next = cwbsc_pkg::ST_SHIFT;
                end
            end
            cwbsc_pkg::ST_SHIFT:
            begin
                if (load_rise)
                begin
                    state_next = cwbsc_pkg::ST_RUN;
                end
            end
            cwbsc_pkg::ST_RUN:
            begin
                if (!load_lvl_reg)
                begin
                    state_next = cwbsc_pkg::ST_SHIFT;
                end
            end
            default:
            begin
                state_next = cwbsc_pkg::ST_UNPROG;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= cwbsc_pkg::ST_UNPROG;
        end
        else if (CE_I)
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            CONFIG_LOADED_O <= 1'h0;
        end
        else if (load_rise)
        begin
            CONFIG_LOADED_O <= 1'h1;
        end
    end

    // ------------------------------------------------------------
    // front end settings, active only from strobe rise
    // ------------------------------------------------------------

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            FRONT_END_O <= '0;
        end
        else if (load_rise)
        begin
            FRONT_END_O.impedance_select <=
                shift_reg[`CWBSC_IMP_MSB:`CWBSC_IMP_LSB];
            FRONT_END_O.amp_gain_select <= shift_reg[`CWBSC_GAIN_POS];
            FRONT_END_O.open_feedback <=
                shift_reg[`CWBSC_GAIN_POS] && shift_reg[`CWBSC_OPEN_FB_POS];
            FRONT_END_O.aaf_cutoff_select <=
                shift_reg[`CWBSC_AAF_MSB:`CWBSC_AAF_LSB];
        end
    end

    // ------------------------------------------------------------
    // per channel phase dividers
    // ------------------------------------------------------------

    logic [NUM_CH-1:0] ch_off_reg;
    logic [3:0] div_reg [NUM_CH];

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            ch_off_reg <= {NUM_CH{1'h1}};
            CH_PHASE_O <= '0;
        end
        else if (load_rise)
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                ch_off_reg[k] <= shift_reg[`CWBSC_CH_W*k];
                CH_PHASE_O[4*k +: 4] <=
                    phase_index(shift_reg[`CWBSC_CH_W*k +: `CWBSC_CH_W]);
            end
        end
    end

    // preset on strobe rise, count on reference rises afterwards
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                div_reg[k] <= `CWBSC_PH_RESET;
            end
        end
        else if (load_rise)
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                div_reg[k] <= phase_index(shift_reg[`CWBSC_CH_W*k +: `CWBSC_CH_W]);
            end
        end
        else if (ref_rise && state_reg == cwbsc_pkg::ST_RUN)
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                div_reg[k] <= div_reg[k] + 4'h1;
            end
        end
    end

    // enables and quadrature lo outputs
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
        begin
            CH_ENABLE_O <= '0;
            LO_I_O <= '0;
            LO_Q_O <= '0;
        end
        else if (CE_I)
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                CH_ENABLE_O[k] <= CONFIG_LOADED_O && !ch_off_reg[k] && !pd_lvl_reg;
                LO_I_O[k] <= div_reg[k][3] && !ch_off_reg[k] && !pd_lvl_reg;
                LO_Q_O[k] <= quad_msb(div_reg[k]) && !ch_off_reg[k] && !pd_lvl_reg;
            end
        end
    end

endmodule : cwbsc_top

`default_nettype wire
